// >>> design/rnbs_top.sv
/*
 Bid scheduler and route filter for the remote_network_port, master or slave role,
 with an AXI4-Lite register slave.
 Assumes frame headers and transaction-done events are delivered synchronously
 by the port's framing logic.
*/
`timescale 1ns/1ps
module rnbs_top import rnbs_pkg::*; #(
   parameter int unsigned TICK_CYC = TICK_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire rnbs_rx_t link_rx,
   input wire logic link_txn_done,
   input wire logic nrm_arrive,
   input wire rnbs_loc_t loc_msg,
   output logic loc_ready,
   output rnbs_mtx_t mst_tx,
   output rnbs_stx_t slv_tx,
   output logic deliver,
   output logic forward,
   output logic bcast,
   output logic bcast_ports
);
   logic aw_got_r, w_got_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic [AXI_AW-1:0] awaddr_r;
   logic [31:0] wdata_r, wmask, wmask_r, rd_mux, rdata_r;
   logic [1:0] bresp_r, rresp_r;
   logic wr_commit, wr_map, rd_map;
   logic [2:0] ctrl_r;
   logic [6:0] drop_r;
   logic [8:0] bid_val_r;
   logic [15:0] reply_r, ivl_r;
   logic bid_req_r, bid_take;
   rnbs_mst_st_t mst_st_r, mst_nxt;
   rnbs_slv_st_t slv_st_r, slv_nxt;
   rnbs_bid_mode_t mode_r, mode_nxt, req_mode;
   logic [6:0] cur_r, cur_nxt, start_r, start_nxt, req_drop;
   logic ret_ivl_r, ret_ivl_nxt, m_bid, m_send;
   logic [7:0] nrm_cnt_r;
   logic [31:0] pres_r;
   logic [15:0] units_r, tmr_units;
   logic tmr_run_r, tmr_done, tmr_load, tmr_pause;
   logic [7:0] cmd_mem [CMD_DEPTH];
   logic [CMD_PTR_W-1:0] wr_ptr_r, rd_ptr_r;
   logic [3:0] cnt_r, cnt_nxt;
   logic push, pop, is_master, clr;
   logic own_bid, rpt_hop, own_hop, bc_hit;
   rnbs_mtx_t mtx_r;
   rnbs_stx_t stx_r;
   logic loc_ready_r, deliver_r, forward_r, bcast_r, bports_r;

   assign is_master = ctrl_r[CTRL_MASTER_BIT];
   assign clr = ctrl_r[CTRL_CLR_BIT];

   // AXI4-Lite write: address and data taken in either order
   assign wr_commit = aw_got_r && w_got_r && !bvalid_r;
   assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}},
                   {8{s_axi_wstrb[0]}}};
   assign wr_map = (awaddr_r == REG_CTRL) || (awaddr_r == REG_DROP) || (awaddr_r == REG_BID)
                   || (awaddr_r == REG_REPLY) || (awaddr_r == REG_IVL)
                   || (awaddr_r == REG_STAT);
   assign rd_map = (s_axi_araddr == REG_CTRL) || (s_axi_araddr == REG_DROP)
                   || (s_axi_araddr == REG_BID) || (s_axi_araddr == REG_REPLY)
                   || (s_axi_araddr == REG_IVL) || (s_axi_araddr == REG_STAT);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         awready_r <= 1'b0;
         awaddr_r <= '0;
      end else if (ce) begin
         if (s_axi_awvalid && awready_r) begin
            aw_got_r <= 1'b1;
            awready_r <= 1'b0;
            awaddr_r <= s_axi_awaddr;
         end else if (wr_commit) begin
            aw_got_r <= 1'b0;
         end else if (!aw_got_r && !bvalid_r) begin
            awready_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_got_r <= 1'b0;
         wready_r <= 1'b0;
         wdata_r <= '0;
         wmask_r <= '0;
      end else if (ce) begin
         if (s_axi_wvalid && wready_r) begin
            w_got_r <= 1'b1;
            wready_r <= 1'b0;
            wdata_r <= s_axi_wdata & wmask;
            // Strobes only mean something while wvalid stands, so keep them
            wmask_r <= wmask;
         end else if (wr_commit) begin
            w_got_r <= 1'b0;
         end else if (!w_got_r && !bvalid_r) begin
            wready_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (ce) begin
         if (wr_commit) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_map ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Byte lanes not strobed keep their old value: wdata_r is pre-masked
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= CTRL_RST;
         drop_r <= DROP_RST;
         bid_val_r <= BID_RST;
         reply_r <= REPLY_RST;
         ivl_r <= IVL_RST;
      end else if (ce && wr_commit) begin
         if (awaddr_r == REG_CTRL) begin
            ctrl_r <= ctrl_r & ~wmask_r[2:0] | wdata_r[2:0];
         end else if (awaddr_r == REG_DROP) begin
            drop_r <= drop_r & ~wmask_r[6:0] | wdata_r[6:0];
         end else if (awaddr_r == REG_BID) begin
            bid_val_r <= bid_val_r & ~wmask_r[8:0] | wdata_r[8:0];
         end else if (awaddr_r == REG_REPLY) begin
            reply_r <= reply_r & ~wmask_r[15:0] | wdata_r[15:0];
         end else if (awaddr_r == REG_IVL) begin
            ivl_r <= ivl_r & ~wmask_r[15:0] | wdata_r[15:0];
         end
      end
   end

   // A new bid write wins over the master taking the previous one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bid_req_r <= 1'b0;
      end else if (ce) begin
         if (wr_commit && awaddr_r == REG_BID && (wdata_r[8:0] | bid_val_r & ~wmask_r[8:0])
             < BID_LIMIT) begin
            bid_req_r <= 1'b1;
         end else if (bid_take) begin
            bid_req_r <= 1'b0;
         end
      end
   end

   always_comb begin
      rd_mux = 32'h0;
      if (s_axi_araddr == REG_CTRL) begin
         rd_mux = {29'h0, ctrl_r};
      end else if (s_axi_araddr == REG_DROP) begin
         rd_mux = {25'h0, drop_r};
      end else if (s_axi_araddr == REG_BID) begin
         rd_mux = {23'h0, bid_val_r};
      end else if (s_axi_araddr == REG_REPLY) begin
         rd_mux = {16'h0, reply_r};
      end else if (s_axi_araddr == REG_IVL) begin
         rd_mux = {16'h0, ivl_r};
      end else if (s_axi_araddr == REG_STAT) begin
         rd_mux[STAT_DROP_LSB +: 7] = cur_r;
         rd_mux[STAT_CNT_LSB +: 4] = cnt_r;
         rd_mux[STAT_NRM_LSB +: 8] = nrm_cnt_r;
         rd_mux[STAT_MST_LSB +: 5] = mst_st_r;
         rd_mux[STAT_SLV_LSB +: 2] = slv_st_r;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= rd_map ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
         end else if (!rvalid_r) begin
            arready_r <= 1'b1;
         end
      end
   end

   // Shared 10 ms timer; roles are exclusive so one is enough
   assign tmr_done = tmr_run_r && (units_r == 16'h0);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pres_r <= '0;
         units_r <= '0;
         tmr_run_r <= 1'b0;
      end else if (ce) begin
         if (tmr_load) begin
            pres_r <= '0;
            units_r <= tmr_units;
            tmr_run_r <= 1'b1;
         end else if (tmr_run_r && !tmr_done && !tmr_pause) begin
            if (pres_r == 32'(TICK_CYC - 1)) begin
               pres_r <= '0;
               units_r <= units_r - 16'h1;
            end else begin
               pres_r <= pres_r + 32'h1;
            end
         end
      end
   end

   always_comb begin
      req_mode = BM_LOOP;
      req_drop = 7'(bid_val_r - BID_LOOP_BASE);
      if (bid_val_r < BID_AUTO_BASE) begin
         req_mode = BM_SINGLE;
         req_drop = 7'(bid_val_r);
      end else if (bid_val_r < BID_CONT_BASE) begin
         req_mode = BM_AUTO;
         req_drop = 7'(bid_val_r - BID_AUTO_BASE);
      end else if (bid_val_r < BID_LOOP_BASE) begin
         req_mode = BM_CONT;
         req_drop = 7'(bid_val_r - BID_CONT_BASE);
      end
   end

   // Master bid sequencer
   always_comb begin
      mst_nxt = mst_st_r;
      mode_nxt = mode_r;
      cur_nxt = cur_r;
      start_nxt = start_r;
      ret_ivl_nxt = ret_ivl_r;
      m_bid = 1'b0;
      m_send = 1'b0;
      bid_take = 1'b0;
      tmr_load = 1'b0;
      tmr_units = reply_r;
      tmr_pause = is_master && mst_st_r == M_NORMAL;
      case (mst_st_r)
         M_IDLE: begin
            if (!is_master || ctrl_r[CTRL_MDIS_BIT]) begin
               mst_nxt = M_IDLE;
            end else if (nrm_cnt_r != 8'h0) begin
               m_send = 1'b1;
               ret_ivl_nxt = 1'b0;
               mst_nxt = M_NORMAL;
            end else if (bid_req_r) begin
               bid_take = 1'b1;
               mode_nxt = req_mode;
               cur_nxt = req_drop;
               start_nxt = req_drop;
               mst_nxt = M_BID;
            end
         end
         M_BID: begin
            m_bid = 1'b1;
            tmr_load = 1'b1;
            mst_nxt = M_WAIT;
         end
         M_WAIT: begin
            // Normal traffic stays queued here while the bid is open
            if (link_txn_done || tmr_done) begin
               tmr_load = 1'b1;
               tmr_units = ivl_r;
               mst_nxt = M_IVL;
            end
         end
         M_IVL: begin
            if (nrm_cnt_r != 8'h0) begin
               m_send = 1'b1;
               ret_ivl_nxt = 1'b1;
               mst_nxt = M_NORMAL;
            end else if (tmr_done) begin
               mst_nxt = M_BID;
               if (bid_req_r && !ctrl_r[CTRL_MDIS_BIT]) begin
                  bid_take = 1'b1;
                  mode_nxt = req_mode;
                  cur_nxt = req_drop;
                  start_nxt = req_drop;
               end else if (!is_master || ctrl_r[CTRL_MDIS_BIT] || mode_r == BM_SINGLE) begin
                  mst_nxt = M_IDLE;
               end else if (mode_r == BM_AUTO) begin
                  if (cur_r == 7'h0) begin
                     mst_nxt = M_IDLE;
                  end else begin
                     cur_nxt = cur_r - 7'h1;
                  end
               end else if (mode_r == BM_LOOP) begin
                  cur_nxt = (cur_r == 7'h0) ? start_r : cur_r - 7'h1;
               end
               // Continuous single mode keeps cur_r
            end
         end
         M_NORMAL: begin
            if (link_txn_done) begin
               mst_nxt = ret_ivl_r ? M_IVL : M_IDLE;
            end
         end
         default: mst_nxt = M_IDLE;
      endcase
      if (!is_master) begin
         tmr_load = slv_st_r == S_IDLE && slv_nxt == S_TXN;
         tmr_units = reply_r;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mst_st_r <= M_IDLE;
         mode_r <= BM_SINGLE;
         cur_r <= 7'h0;
         start_r <= 7'h0;
         ret_ivl_r <= 1'b0;
         mtx_r <= '0;
      end else if (ce) begin
         mst_st_r <= mst_nxt;
         mode_r <= mode_nxt;
         cur_r <= cur_nxt;
         start_r <= start_nxt;
         ret_ivl_r <= ret_ivl_nxt;
         mtx_r.bid <= m_bid;
         mtx_r.nrm_send <= m_send;
         if (m_bid) begin
            mtx_r.drop <= cur_r;
         end
      end
   end

   // Queued master traffic; saturates rather than wrap
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nrm_cnt_r <= 8'h0;
      end else if (ce) begin
         if (nrm_arrive && !m_send && nrm_cnt_r != 8'hff) begin
            nrm_cnt_r <= nrm_cnt_r + 8'h1;
         end else if (m_send && !nrm_arrive) begin
            nrm_cnt_r <= nrm_cnt_r - 8'h1;
         end
      end
   end

   // Slave route decode
   assign own_hop = link_rx.hop == {1'b0, drop_r};
   assign rpt_hop = link_rx.hop == 8'({1'b0, drop_r} + ROUTE_RPT_OFS);
   assign own_bid = !is_master && link_rx.vld && link_rx.is_bid && own_hop;
   assign bc_hit = link_rx.hop == BC_ALL_EVEN || link_rx.hop == BC_ALL_ODD
                   || (link_rx.hop >= BC_DECADE_LO && link_rx.hop < BC_ALL_ODD
                   && 4'((link_rx.hop - BC_DECADE_LO) >> 1) == 4'(drop_r / DROP_DECADE));

   // Indirect bids (hop drop+100) never reach own_bid
   always_comb begin
      slv_nxt = slv_st_r;
      pop = 1'b0;
      case (slv_st_r)
         S_IDLE: begin
            if (own_bid && cnt_r != 4'h0 && !clr) begin
               pop = 1'b1;
               slv_nxt = S_TXN;
            end
         end
         S_TXN: begin
            if (link_txn_done || tmr_done || is_master) begin
               slv_nxt = S_IDLE;
            end
         end
         default: slv_nxt = S_IDLE;
      endcase
   end

   assign push = loc_msg.vld && loc_ready_r && !is_master;
   assign cnt_nxt = cnt_r + {3'h0, push} - {3'h0, pop};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r <= 4'h0;
         loc_ready_r <= 1'b0;
      end else if (ce) begin
         if (clr) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= 4'h0;
            loc_ready_r <= 1'b0;
         end else begin
            wr_ptr_r <= wr_ptr_r + CMD_PTR_W'(push);
            rd_ptr_r <= rd_ptr_r + CMD_PTR_W'(pop);
            cnt_r <= cnt_nxt;
            loc_ready_r <= !is_master && cnt_nxt < CMD_DEPTH_C;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (ce && push) begin
         cmd_mem[wr_ptr_r] <= loc_msg.tag;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slv_st_r <= S_IDLE;
         stx_r <= '0;
         deliver_r <= 1'b0;
         forward_r <= 1'b0;
         bcast_r <= 1'b0;
         bports_r <= 1'b0;
      end else if (ce) begin
         slv_st_r <= slv_nxt;
         stx_r.go <= pop;
         stx_r.busy <= slv_nxt == S_TXN;
         if (pop) begin
            stx_r.tag <= cmd_mem[rd_ptr_r];
         end
         deliver_r <= !is_master && link_rx.vld && !link_rx.is_bid && own_hop;
         forward_r <= !is_master && link_rx.vld && !link_rx.is_bid && rpt_hop;
         bcast_r <= !is_master && link_rx.vld && !link_rx.is_bid && bc_hit;
         bports_r <= !is_master && link_rx.vld && !link_rx.is_bid && bc_hit
                     && link_rx.last254;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign loc_ready = loc_ready_r;
   assign mst_tx = mtx_r;
   assign slv_tx = stx_r;
   assign deliver = deliver_r;
   assign forward = forward_r;
   assign bcast = bcast_r;
   assign bcast_ports = bports_r;

   sequence s_own_bid_full;
      ce && slv_st_r == S_IDLE && own_bid && cnt_r != 4'h0 && !clr;
   endsequence
   sequence s_go_busy;
      stx_r.go && stx_r.busy;
   endsequence
   property p_go_on_bid;
      @(posedge aclk) disable iff (!aresetn) s_own_bid_full |=> s_go_busy;
   endproperty
   a_go_on_bid: assert property (p_go_on_bid) else $error("bid with data not answered");
   property p_go_cause;
      @(posedge aclk) disable iff (!aresetn)
         $rose(stx_r.go) |-> $past(own_bid) && $past(cnt_r) != 4'h0;
   endproperty
   a_go_cause: assert property (p_go_cause) else $error("slave sent without own bid");
   property p_empty_silent;
      @(posedge aclk) disable iff (!aresetn)
         ce && own_bid && cnt_r == 4'h0 |=> !stx_r.go;
   endproperty
   a_empty_silent: assert property (p_empty_silent) else $error("empty slave replied");
   property p_no_indirect;
      @(posedge aclk) disable iff (!aresetn)
         ce && link_rx.vld && link_rx.is_bid && rpt_hop && slv_st_r == S_IDLE |=> !stx_r.go;
   endproperty
   a_no_indirect: assert property (p_no_indirect) else $error("indirect bid executed");
   property p_one_per_bid;
      @(posedge aclk) disable iff (!aresetn)
         $past(ce) && stx_r.busy && $past(stx_r.busy) |-> !stx_r.go;
   endproperty
   a_one_per_bid: assert property (p_one_per_bid) else $error("second message in one bid");
   property p_bid100;
      @(posedge aclk) disable iff (!aresetn)
         ce && bid_take && bid_val_r == BID_AUTO_BASE ##1 ce |=> mtx_r.bid && mtx_r.drop == 7'h0;
   endproperty
   a_bid100: assert property (p_bid100) else $error("bid value 100 not drop 0");
   property p_quiet_open_bid;
      @(posedge aclk) disable iff (!aresetn)
         $past(ce) && mst_st_r == M_WAIT && $past(mst_st_r) == M_WAIT
         |-> !mtx_r.nrm_send && !mtx_r.bid;
   endproperty
   a_quiet_open_bid: assert property (p_quiet_open_bid) else $error("master sent in bid");
   property p_repeat;
      @(posedge aclk) disable iff (!aresetn)
         ce && link_rx.vld && !link_rx.is_bid && rpt_hop && !is_master |=> forward_r;
   endproperty
   a_repeat: assert property (p_repeat) else $error("repeater hop not forwarded");
   property p_bcast_all;
      @(posedge aclk) disable iff (!aresetn)
         ce && !is_master && link_rx.vld && !link_rx.is_bid && link_rx.hop == BC_ALL_ODD
         |=> bcast_r;
   endproperty
   a_bcast_all: assert property (p_bcast_all) else $error("general broadcast missed");
endmodule // rnbs_top

// >>> design/rnbs_pkg.sv
/*
 Constants, types and carriers for the radio network bid scheduler.
 Assumes a single 200 MHz clock and an AXI4-Lite register master.
*/
package rnbs_pkg;
   localparam int AXI_AW = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_DROP = 8'h04;
   localparam logic [7:0] REG_BID = 8'h08;
   localparam logic [7:0] REG_REPLY = 8'h0c;
   localparam logic [7:0] REG_IVL = 8'h10;
   localparam logic [7:0] REG_STAT = 8'h14;
   localparam int CTRL_MASTER_BIT = 0;
   localparam int CTRL_MDIS_BIT = 1;
   localparam int CTRL_CLR_BIT = 2;
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [6:0] DROP_RST = 7'h00;
   localparam logic [8:0] BID_RST = 9'h000;
   localparam logic [15:0] REPLY_RST = 16'h00c8;
   localparam logic [15:0] IVL_RST = 16'h000a;
   localparam int STAT_DROP_LSB = 0;
   localparam int STAT_CNT_LSB = 8;
   localparam int STAT_NRM_LSB = 12;
   localparam int STAT_MST_LSB = 20;
   localparam int STAT_SLV_LSB = 25;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Timer unit is 10 ms
   localparam longint TICK_NS = 10000000;
   localparam longint CLK_PERIOD_NS = 5;
   localparam int unsigned TICK_CYCLES = int'(TICK_NS / CLK_PERIOD_NS);
   localparam logic [8:0] BID_AUTO_BASE = 9'h064;
   localparam logic [8:0] BID_CONT_BASE = 9'h0c8;
   localparam logic [8:0] BID_LOOP_BASE = 9'h12c;
   localparam logic [8:0] BID_LIMIT = 9'h190;
   localparam logic [7:0] ROUTE_RPT_OFS = 8'h64;
   localparam logic [7:0] BC_ALL_EVEN = 8'hfe;
   localparam logic [7:0] BC_ALL_ODD = 8'hfd;
   localparam logic [7:0] BC_DECADE_LO = 8'he9;
   localparam logic [6:0] DROP_DECADE = 7'h0a;
   localparam int CMD_DEPTH = 8;
   localparam int CMD_PTR_W = 3;
   localparam logic [3:0] CMD_DEPTH_C = 4'h8;

   typedef enum logic [4:0] {
      M_IDLE = 5'b00001,
      M_BID = 5'b00010,
      M_WAIT = 5'b00100,
      M_IVL = 5'b01000,
      M_NORMAL = 5'b10000
   } rnbs_mst_st_t;
   typedef enum logic [1:0] {
      S_IDLE = 2'b01,
      S_TXN = 2'b10
   } rnbs_slv_st_t;
   typedef enum logic [1:0] {
      BM_SINGLE = 2'h0,
      BM_AUTO = 2'h1,
      BM_CONT = 2'h2,
      BM_LOOP = 2'h3
   } rnbs_bid_mode_t;

   // Frame header seen on the remote_network_port
   typedef struct packed {
      logic vld;
      logic is_bid;
      logic [7:0] hop;
      logic last254;
   } rnbs_rx_t;
   typedef struct packed {
      logic vld;
      logic [7:0] tag;
   } rnbs_loc_t;
   typedef struct packed {
      logic bid;
      logic [6:0] drop;
      logic nrm_send;
   } rnbs_mtx_t;
   typedef struct packed {
      logic go;
      logic [7:0] tag;
      logic busy;
   } rnbs_stx_t;
endpackage

// >>> bench/rnbs_far.sv
/* Far-side unit model on the link.
 Assumes go and nrm_send are one-cycle pulses on aclk. */
`timescale 1ns/1ps
module rnbs_far import rnbs_pkg::*; (
   input wire logic aclk,
   input wire rnbs_stx_t slv_tx,
   input wire rnbs_mtx_t mst_tx,
   input wire logic [3:0] dly,
   output logic link_txn_done
);
   // Bids get no answer: an empty slave
   // One transaction at a time; dly varies prompt and slow
   always @(posedge aclk) begin
      if (slv_tx.go || mst_tx.nrm_send) begin
         repeat (dly) @(posedge aclk);
         link_txn_done <= 1;
         @(posedge aclk);
      end
      link_txn_done <= 0;
   end
endmodule // rnbs_far

// >>> bench/testbench.sv
/* Bench: register bus, slave bid and route table, master bid modes.
 Assumes a 4-cycle tick and the rnbs_far partner. */
`timescale 1ns/1ps
module testbench import rnbs_pkg::*; ;
   logic aclk = 0, aresetn = 0, ce = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, nrm_arrive = 0, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, loc_ready, deliver, forward, bcast;
   logic bcast_ports, link_txn_done;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_d;
   logic [3:0] s_axi_wstrb = 4'hf, dly = 0;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [13:0] obs;
   rnbs_rx_t link_rx = '0;
   rnbs_loc_t loc_msg = '0;
   rnbs_mtx_t mst_tx;
   rnbs_stx_t slv_tx;
   int num_errors = 0, checks_done = 0, nsent, i, j, k;
   logic [6:0] q[$];
   localparam int MODES[5] = '{5, 100, 102, 203, 302};
   // Frame kind, hop, last254, expected {go, tag, busy, route pulses}; own drop is 21
   localparam logic [23:0] ROWS[9] = '{
      {1'b1, 8'd21, 1'b0, 14'h3430}, // Oldest first
      {1'b1, 8'd121, 1'b0, 14'h0}, // Via repeater
      {1'b1, 8'd21, 1'b0, 14'h3450}, // No hold-off
      {1'b1, 8'd21, 1'b0, 14'h0}, // Empty
      {1'b0, 8'd21, 1'b0, 14'h8}, // Plain drop
      {1'b0, 8'd121, 1'b0, 14'h4}, // Repeater
      {1'b0, 8'd237, 1'b1, 14'h3}, // Own decade
      {1'b0, 8'd240, 1'b0, 14'h0}, // Other decade
      {1'b0, 8'd253, 1'b0, 14'h2}}; // All
   rnbs_top #(.TICK_CYC(4)) DUT (.*);
   rnbs_far far (.aclk(aclk), .slv_tx(slv_tx), .mst_tx(mst_tx), .dly(dly),
      .link_txn_done(link_txn_done));
   initial forever #2.5 aclk = ~aclk;
   always @(posedge aclk) begin
      if (mst_tx.bid) q.push_back(mst_tx.drop);
      if (mst_tx.nrm_send) nsent++;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      rd_d = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 0;
      @(posedge aclk);
   endtask
   task automatic snd(input logic [23:0] r);
      @(posedge aclk);
      link_rx <= '{1'b1, r[23], r[22:15], r[14]};
      @(posedge aclk);
      link_rx <= '0;
      #1;
      obs = r[23] ? {slv_tx.go, slv_tx.go ? slv_tx.tag : 8'h0, slv_tx.busy, 4'h0}
         : {10'h0, deliver, forward, bcast, bcast_ports};
   endtask
   function automatic logic [6:0] expd(input int v, input int i);
      int n = v % 100;
      if (v / 100 == 1) return 7'(n - i);
      if (v / 100 == 3) return 7'(n - i % (n + 1));
      return 7'(n);
   endfunction
   task automatic mst(input int v);
      aresetn <= 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      wr(REG_CTRL, 32'h1);
      wr(REG_REPLY, 32'h1);
      wr(REG_IVL, 32'h1);
      q = {};
      nsent = 0;
      wr(REG_BID, v);
      repeat (30) @(posedge aclk);
      nrm_arrive <= 1;
      @(posedge aclk);
      nrm_arrive <= 0;
      repeat (200) @(posedge aclk);
      k = v < 100 ? 1 : v < 200 ? v % 100 + 1 : 4;
      chk("bids", 1, v < 200 ? q.size() == k : q.size() >= k);
      for (i = 0; i < k; i++) chk("drop", expd(v, i), q[i]);
      chk("normal", 1, nsent);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      rd(REG_REPLY);
      chk("reply_reset", {16'h0, REPLY_RST}, rd_d);
      rd(8'h20);
      chk("unmapped", RESP_SLVERR, resp);
      wr(8'h20, 32'h0);
      chk("wr_unmapped", RESP_SLVERR, resp);
      wr(REG_DROP, 32'h15);
      chk("wr_okay", RESP_OKAY, resp);
      wr(REG_REPLY, 32'h3);
      wr(8'h00, 32'h0);
      loc_msg <= '{1'b1, 8'ha1};
      do @(posedge aclk); while (!loc_ready);
      loc_msg <= '{1'b1, 8'ha2};
      do @(posedge aclk); while (!loc_ready);
      loc_msg <= '0;
      for (j = 0; j < 9; j++) begin
         dly = 4'(j * 3);
         snd(ROWS[j]);
         chk("slave_row", ROWS[j][13:0], obs);
         for (i = 0; i < 30 && slv_tx.busy; i++) @(posedge aclk);
         chk("busy", 0, slv_tx.busy);
      end
      loc_msg <= '{1'b1, 8'ha3};
      do @(posedge aclk); while (!loc_ready);
      loc_msg <= '0;
      wr(REG_CTRL, 32'h4);
      wr(REG_CTRL, 32'h0);
      rd(REG_STAT);
      chk("flushed", 0, rd_d[STAT_CNT_LSB +: 4]);
      // A frame seen while frozen must leave no pulse behind
      ce <= 0;
      snd(ROWS[4]);
      chk("frozen", 0, obs);
      @(posedge aclk);
      ce <= 1;
      $display("test slave done");
      dly = 4'h2;
      foreach (MODES[m]) mst(MODES[m]);
      wr(REG_CTRL, 32'h3);
      repeat (20) @(posedge aclk);
      q = {};
      wr(REG_BID, 32'h5);
      repeat (40) @(posedge aclk);
      chk("disabled", 0, q.size());
      $display("test master done");
      give_verdict();
   end
   // Cut a hang short well past the expected run time
   initial begin
      #20000;
      num_errors++;
      give_verdict();
   end
endmodule // testbench
